// file: dv/core_model.sv
// Processor core model that takes offered interrupts
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Offer and answer
  input wire logic irq_req,
  input wire logic [7:0] irq_type,
  input wire logic [3:0] wait_n,
  output logic irq_ack,
  // Record of taken interrupts
  output logic [7:0] last_type,
  output logic [7:0] n_taken
);
  logic [3:0] cnt_q;
  // Ack is one pulse; a held ack would take the next offer unasked
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_ack <= 1'b0;
      cnt_q <= 4'h0;
      last_type <= 8'h00;
      n_taken <= 8'h00;
    end
    else
    begin
      irq_ack <= 1'b0;
      cnt_q <= 4'h0;
      if (irq_ack && irq_req)
      begin
        last_type <= irq_type;
        n_taken <= n_taken + 8'h01;
      end
      else if (irq_req && !irq_ack)
      begin
        if (cnt_q >= wait_n)
          irq_ack <= 1'b1;
        else
          cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/interrupt_source_control_sva.sv
// Port checks of the interrupt source control block
`timescale 1ns/1ps
`default_nettype none
module interrupt_source_control_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Requests and answers
  input wire logic [2:0] tmr_req,
  input wire logic [1:0] ser_req,
  input wire logic irq_req,
  input wire logic [7:0] irq_type,
  input wire logic irq_ack,
  input wire logic irq_ack_out_a,
  input wire logic irq_ack_out_a_oe_n,
  input wire logic irq_ack_out_b,
  input wire logic irq_ack_out_b_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic took_q;
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      took_q <= 1'b0;
    else
      took_q <= irq_req & irq_ack;
  a_ack_drop: assert property (irq_req && irq_ack |=> !irq_req)
    else $error("offer kept after acknowledge");
  a_reset_idle: assert property ($rose(rst_b) |-> !irq_req && irq_ack_out_a_oe_n && irq_ack_out_b_oe_n)
    else $error("not idle after reset");
  a_ack_drive: assert property (irq_ack_out_a |-> !irq_ack_out_a_oe_n)
    else $error("ack pulse while pin not driven");
  a_ack_pulse: assert property (irq_ack_out_a |=> !irq_ack_out_a)
    else $error("ack pulse too long");
  a_ack_cause: assert property (irq_ack_out_a |-> took_q || $past(took_q))
    else $error("ack pulse without a taken interrupt");
  a_ack_b_drive: assert property (irq_ack_out_b |-> !irq_ack_out_b_oe_n)
    else $error("second ack pulse while pin not driven");
  a_ack_b_cause: assert property (irq_ack_out_b |-> took_q)
    else $error("second ack pulse without a taken interrupt");
  a_type_legal: assert property (irq_req |-> irq_type inside
    {8'h08, 8'h12, 8'h13, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h16, 8'h17})
    else $error("unknown vector type");
  a_ser_cause: assert property (irq_req && irq_type == 8'h17 |-> $past(ser_req[0]))
    else $error("serial offer without request");
  a_tmr_cause: assert property (irq_req && irq_type == 8'h08 |-> $past(tmr_req[0]))
    else $error("timer offer without request");
  c_take: cover property (irq_req && irq_ack);
  c_casc: cover property (irq_ack_out_a);
  c_casc_b: cover property (irq_ack_out_b);
  c_ser: cover property (irq_req && irq_type == 8'h17);
endmodule
bind interrupt_source_control interrupt_source_control_sva u_sva (.*);
`default_nettype wire

// file: dv/interrupt_source_control_test.sv
// Register and interrupt tests of the source control block
`timescale 1ns/1ps
`default_nettype none
module interrupt_source_control_test;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb = 4'h3, wait_n = 4'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_req, irq_ack;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, dma_req = 0, ser_req = 0;
  logic slave_mode_pin = 0, ext_irq_in_a = 0, ext_irq_in_b = 0, ext_irq_in_c = 0, ext_irq_in_d = 0, ext_irq_in_e = 0;
  logic irq_ack_out_a, irq_ack_out_a_oe_n, irq_ack_out_b, irq_ack_out_b_oe_n;
  logic [2:0] tmr_req = 0;
  logic [7:0] irq_type, last_type, n_taken;
  int n_mismatch = 0, checks = 0, cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  interrupt_source_control u_interrupt_source_control (.*);
  core_model u_core_model (.*);
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] i, input logic [15:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= {2'b00, i, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] i);
    @(posedge sys_clk);
    s_axi_araddr <= {2'b00, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd_v = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task rdc(input string nm, input logic [7:0] i, input logic [15:0] e);
    rd(i);
    chk(nm, {16'h0000, e}, rd_v);
  endtask
  // Clearing all in-service bits lets the next source through
  task clr;
    wr(8'h2c, 16'h0fff);
  endtask
  task take(input logic [7:0] e);
    logic [7:0] n0;
    n0 = n_taken;
    while (n_taken === n0) @(posedge sys_clk);
    chk("irq_type", {24'h0, e}, {24'h0, last_type});
  endtask
  task quiet;
    logic [7:0] n0;
    n0 = n_taken;
    repeat (20) @(posedge sys_clk);
    chk("no_take", {24'h0, n0}, {24'h0, n_taken});
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      stop_test;
    end
  end
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int i = 'h32; i <= 'h44; i += 2)
      rdc("reset", i[7:0], i >= 'h42 ? 16'h001f : 16'h000f);
    rd(8'h46);
    chk("unmapped", 32'h0000_0002, {rd_v[29:0], rsp});
    for (int i = 'h32; i <= 'h44; i += 2)
    begin
      wr(i[7:0], 16'hffff);
      rdc("fields", i[7:0], i == 'h38 || i == 'h3a ? 16'h007f : i >= 'h3c ? 16'h001f : 16'h000f);
      wr(i[7:0], 16'h000f);
    end
    rdc("mirror", 8'h28, 16'h0fff);
    wr(8'h38, 16'h0007);
    rdc("mirror", 8'h28, 16'h0ff7);
    wr(8'h28, 16'h0fff);
    rdc("ext0", 8'h38, 16'h000f);
    $display("test registers done");
    wr(8'h42, 16'h0008);
    wr(8'h44, 16'h0003);
    wr(8'h34, 16'h0004);
    wr(8'h32, 16'h0005);
    ser_req <= 2'b11;
    dma_req <= 2'b01;
    tmr_req <= 3'b001;
    take(8'h17);
    take(8'h0a);
    take(8'h08);
    rdc("in_service", 8'h2c, 16'h0405);
    ser_req <= 2'b00;
    dma_req <= 2'b00;
    tmr_req <= 3'b100;
    clr;
    take(8'h13);
    rdc("pending", 8'h2e, 16'h0001);
    tmr_req <= 3'b000;
    clr;
    $display("test on-chip done");
    wr(8'h38, 16'h0021);
    wr(8'h40, 16'h0010);
    ext_irq_in_a <= 1'b1;
    ext_irq_in_e <= 1'b1;
    take(8'h0c);
    ext_irq_in_a <= 1'b0;
    chk("ack_oe_n", 32'h0, {31'h0, irq_ack_out_a_oe_n});
    clr;
    quiet;
    wr(8'h38, 16'h000f);
    take(8'h10);
    ext_irq_in_e <= 1'b0;
    clr;
    wr(8'h40, 16'h0018);
    ext_irq_in_e <= 1'b1;
    quiet;
    ext_irq_in_e <= 1'b0;
    wr(8'h3c, 16'h0001);
    ext_irq_in_c <= 1'b1;
    take(8'h0e);
    clr;
    quiet;
    ext_irq_in_c <= 1'b0;
    // Nested re-entry while still in service
    wr(8'h3a, 16'h0060);
    ext_irq_in_b <= 1'b1;
    take(8'h0d);
    chk("ack_b_oe_n", 32'h0, {31'h0, irq_ack_out_b_oe_n});
    ext_irq_in_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    ext_irq_in_b <= 1'b1;
    take(8'h0d);
    ext_irq_in_b <= 1'b0;
    $display("test pins done");
    slave_mode_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(8'h3c);
    chk("slave_ext2", 32'h0000_0002, {rd_v[29:0], rsp});
    rdc("slave_dma0", 8'h34, 16'h0004);
    rdc("slave_tmr1", 8'h38, 16'h000f);
    wait_n <= 4'h5;
    wr(8'h38, 16'h0002);
    tmr_req <= 3'b010;
    take(8'h12);
    $display("test slave done");
    stop_test;
  end
endmodule
`default_nettype wire

// file: verilog/axil_reg_port.sv
// AXI4-Lite slave that turns bus transfers into register strobes
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_map.svh"
module axil_reg_port (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Write channels
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side
  output logic reg_wr_en,
  output logic [7:0] reg_wr_idx,
  output logic [15:0] reg_wr_data,
  output logic [1:0] reg_wr_be,
  input wire logic reg_wr_ok,
  output logic [7:0] reg_rd_idx,
  input wire logic [15:0] reg_rd_data,
  input wire logic reg_rd_ok
);
  import irq_ctrl_pkg::*;
  axil_st_t q;
  axil_st_t d;
  logic wr_fire;
  logic wr_inside;
  logic rd_inside;
  assign s_axi_awready = !q.aw_full && !q.bvalid;
  assign s_axi_wready = !q.w_full && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign wr_fire = q.aw_full && q.w_full && !q.bvalid;
  assign wr_inside = (q.awaddr[11:10] == 2'b00) && reg_wr_ok;
  assign rd_inside = (s_axi_araddr[11:10] == 2'b00) && reg_rd_ok;
  assign reg_wr_en = wr_fire && wr_inside;
  assign reg_wr_idx = q.awaddr[9:2];
  assign reg_wr_data = q.wdata[15:0];
  assign reg_wr_be = q.wstrb[1:0];
  assign reg_rd_idx = s_axi_araddr[9:2];
  always_comb
  begin
    d = q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      d.aw_full = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      d.w_full = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    // Response only once both halves are held, whatever their order
    if (wr_fire)
    begin
      d.aw_full = 1'b0;
      d.w_full = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = wr_inside ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      d.rvalid = 1'b1;
      d.rdata = rd_inside ? {16'h0000, reg_rd_data} : 32'h0000_0000;
      d.rresp = rd_inside ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
  end
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      q <= '0;
    else
      q <= d;
  end
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
endmodule
`default_nettype wire

// file: verilog/interrupt_source_control.sv
// Per-source interrupt mask, priority, trigger and cascade control with request resolution
//
// Operation
// - Serial control registers reset to 001Fh; bit 4 reads one, upper bits zero.
// - A serial port interrupts only while its mask bit is zero.
// - Three-bit priority, 000b highest to 111b lowest; reset gives lowest.
// - Fifth external input only in fully nested mode; off in cascade.
// - Fifth external input: bit 4 one is high level, zero rising edge.
// - Fifth external input ignored while its mask bit is one.
// - External, timer and DMA control registers reset to 000Fh.
// - Third and fourth external inputs vector as types 0eh and 0fh.
// - In cascade, third and fourth pins become acknowledge outputs.
// - Third and fourth inputs: bit 4 selects level, else rising edge.
// - Each external, timer, DMA mask bit is mirrored in a shared mask register.
// - First and second external inputs vector as types 0ch and 0dh.
// - First and second inputs: bit 5 enables cascade; bits 15 to 7 zero.
// - First and second inputs: bit 6 enables special fully nested operation.
// - First and second inputs: bit 4 selects level, else rising edge.
// - Master mode: one shared timer register; types 08h, 12h, 13h.
// - Timer or DMA mask one blocks all its sources; zero lets any through.
// - Slave mode: per-timer control registers at 032h, 038h and 03ah.
// - DMA interrupts use types 0ah and 0bh.
// - Slave mode keeps DMA control registers at 034h and 036h.
// - Pending timer bit is the OR of the three timer requests in master mode; in slave mode it is timer 0 only.
// - Taken interrupt sets its in-service bit; register resets to zero.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_map.svh"
module interrupt_source_control (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register bus
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Mode strap
  input wire logic slave_mode_pin,
  // External request pins
  input wire logic ext_irq_in_a,
  input wire logic ext_irq_in_b,
  input wire logic ext_irq_in_c,
  input wire logic ext_irq_in_d,
  input wire logic ext_irq_in_e,
  // Cascade acknowledge drive on the third and fourth pins
  output logic irq_ack_out_a,
  output logic irq_ack_out_a_oe_n,
  output logic irq_ack_out_b,
  output logic irq_ack_out_b_oe_n,
  // On-chip requests
  input wire logic [2:0] tmr_req,
  input wire logic [1:0] dma_req,
  input wire logic [1:0] ser_req,
  // Processor side
  output logic irq_req,
  output logic [7:0] irq_type,
  input wire logic irq_ack
);
  import irq_ctrl_pkg::*;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic [4:0] ent_of(input logic [7:0] idx, input logic slave);
    if (slave && idx == `IDX_TIMER1_SLAVE)
      ent_of = {1'b1, ENT_TMR1};
    else if (slave && idx == `IDX_TIMER2_SLAVE)
      ent_of = {1'b1, ENT_TMR2};
    else if (idx == `IDX_TIMER_UNIT)
      ent_of = {1'b1, ENT_TMR};
    else if (idx == `IDX_DMA0_EXT5)
      ent_of = {1'b1, ENT_DMA0};
    else if (idx == `IDX_DMA1_EXT6)
      ent_of = {1'b1, ENT_DMA1};
    else if (slave)
      ent_of = 5'h00;
    else if (idx == `IDX_EXT0)
      ent_of = {1'b1, ENT_EXT0};
    else if (idx == `IDX_EXT1)
      ent_of = {1'b1, ENT_EXT1};
    else if (idx == `IDX_EXT2)
      ent_of = {1'b1, ENT_EXT2};
    else if (idx == `IDX_EXT3)
      ent_of = {1'b1, ENT_EXT3};
    else if (idx == `IDX_EXT4)
      ent_of = {1'b1, ENT_EXT4};
    else if (idx == `IDX_SERIAL1)
      ent_of = {1'b1, ENT_SER1};
    else if (idx == `IDX_SERIAL0)
      ent_of = {1'b1, ENT_SER0};
    else
      ent_of = 5'h00;
  endfunction

  // Fields that software may change in each entry
  function automatic logic [6:0] wmask(input logic [3:0] e);
    if (e == ENT_EXT0 || e == ENT_EXT1)
      wmask = `WMASK_EXT01;
    else if (e == ENT_EXT2 || e == ENT_EXT3 || e == ENT_EXT4)
      wmask = `WMASK_EXT234;
    else
      wmask = `WMASK_PLAIN;
  endfunction

  // Bit layout of the pending and in-service views
  function automatic logic [15:0] view(input logic [11:0] v, input logic slave);
    logic [15:0] r;
    r = 16'h0000;
    r[0] = v[0];
    r[2] = v[1];
    r[3] = v[2];
    if (slave)
    begin
      r[4] = v[10];
      r[5] = v[11];
    end
    else
    begin
      r[8:4] = v[7:3];
      r[9] = v[8];
      r[10] = v[9];
    end
    return r;
  endfunction

  // Current read value of a register, with a hit flag on top
  function automatic logic [16:0] reg_value(input logic [7:0] idx, input logic slave,
                                            input ctl_arr_t c, input logic [11:0] isv,
                                            input logic [11:0] rq);
    logic [4:0] en;
    logic [15:0] v;
    en = ent_of(idx, slave);
    v = 16'h0000;
    if (idx == `IDX_MASK_MIRROR)
    begin
      for (int e = 0; e < 12; e++)
        v[e] = c[e].source_mask;
      return {1'b1, v};
    end
    else if (idx == `IDX_IN_SERVICE)
      return {1'b1, view(isv, slave)};
    else if (idx == `IDX_PENDING)
      return {1'b1, view(rq, slave)};
    else if (en[4])
    begin
      v[6:0] = c[en[3:0]] & wmask(en[3:0]);
      if (en[3:0] == ENT_SER0 || en[3:0] == ENT_SER1)
        v[`POS_SER_FIXED] = 1'b1;
      return {1'b1, v};
    end
    return 17'h0_0000;
  endfunction

  // Vector type of the source being forwarded
  function automatic logic [7:0] type_of(input logic [3:0] e, input logic slave,
                                         input logic [2:0] t);
    case (e)
      ENT_TMR: type_of = (slave || t[0]) ? `TYPE_TMR0 : (t[1] ? `TYPE_TMR1 : `TYPE_TMR2);
      ENT_TMR1: type_of = `TYPE_TMR1;
      ENT_TMR2: type_of = `TYPE_TMR2;
      ENT_DMA0: type_of = `TYPE_DMA0;
      ENT_DMA1: type_of = `TYPE_DMA1;
      ENT_EXT0: type_of = `TYPE_EXT0;
      ENT_EXT1: type_of = `TYPE_EXT1;
      ENT_EXT2: type_of = `TYPE_EXT2;
      ENT_EXT3: type_of = `TYPE_EXT3;
      ENT_EXT4: type_of = `TYPE_EXT4;
      ENT_SER1: type_of = `TYPE_SER1;
      default: type_of = `TYPE_SER0;
    endcase
  endfunction

  // ----------------------------------------
  // State and wiring
  // ----------------------------------------
  main_st_t q;
  main_st_t d;
  logic slave;
  logic casc_any;
  logic ack_now;
  logic [4:0] pin_req;
  logic [4:0] pin_clear;
  logic [4:0] pin_in;
  logic [11:0] req;
  logic [11:0] elig;
  logic wr_en;
  logic [7:0] wr_idx;
  logic [15:0] wr_data;
  logic [1:0] wr_be;
  logic [16:0] wr_cur;
  logic [7:0] rd_idx;
  logic [16:0] rd_val;
  logic [4:0] wr_ent;
  logic [15:0] nv;
  logic found;
  logic [3:0] best;
  logic [2:0] best_pri;

  assign slave = q.mode_s2;
  assign casc_any = q.ctl[ENT_EXT0].cascade_enable | q.ctl[ENT_EXT1].cascade_enable;
  assign ack_now = q.irq_req && irq_ack;
  assign pin_in = {ext_irq_in_e, ext_irq_in_d, ext_irq_in_c, ext_irq_in_b, ext_irq_in_a};

  // ----------------------------------------
  // External pin detectors
  // ----------------------------------------
  for (genvar i = 0; i < 5; i++)
  begin : g_pin
    assign pin_clear[i] = ack_now && q.sel == 4'(ENT_EXT0 + i);
    irq_pin_detect u_det (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .pin_in(pin_in[i]),
      .level_mode(q.ctl[ENT_EXT0 + i].level_trigger_select),
      .clear(pin_clear[i]),
      .req(pin_req[i])
    );
  end

  // ----------------------------------------
  // Request gathering
  // ----------------------------------------
  assign req[ENT_TMR] = slave ? tmr_req[0] : |tmr_req;
  assign req[ENT_DMA0] = dma_req[0];
  assign req[ENT_DMA1] = dma_req[1];
  assign req[ENT_EXT0] = !slave && pin_req[0];
  assign req[ENT_EXT1] = !slave && pin_req[1];
  assign req[ENT_EXT2] = !slave && !q.ctl[ENT_EXT0].cascade_enable && pin_req[2];
  assign req[ENT_EXT3] = !slave && !q.ctl[ENT_EXT1].cascade_enable && pin_req[3];
  assign req[ENT_EXT4] = !slave && !casc_any && pin_req[4];
  assign req[ENT_SER1] = ser_req[1];
  assign req[ENT_SER0] = ser_req[0];
  assign req[ENT_TMR1] = slave && tmr_req[1];
  assign req[ENT_TMR2] = slave && tmr_req[2];

  // A masked source never competes; nested re-entry only with special nesting
  for (genvar e = 0; e < 12; e++)
  begin : g_elig
    assign elig[e] = req[e] && !q.ctl[e].source_mask
                     && (!q.in_service_reg[e] || q.ctl[e].special_nested_enable);
  end

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  axil_reg_port u_bus (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .reg_wr_en(wr_en),
    .reg_wr_idx(wr_idx),
    .reg_wr_data(wr_data),
    .reg_wr_be(wr_be),
    .reg_wr_ok(wr_cur[16]),
    .reg_rd_idx(rd_idx),
    .reg_rd_data(rd_val[15:0]),
    .reg_rd_ok(rd_val[16])
  );

  assign rd_val = reg_value(rd_idx, slave, q.ctl, q.in_service_reg, req);
  assign wr_cur = reg_value(wr_idx, slave, q.ctl, q.in_service_reg, req);
  assign wr_ent = ent_of(wr_idx, slave);
  assign nv = {wr_be[1] ? wr_data[15:8] : wr_cur[15:8], wr_be[0] ? wr_data[7:0] : wr_cur[7:0]};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    d = q;
    d.mode_s1 = slave_mode_pin;
    d.mode_s2 = q.mode_s1;
    // Software writes; the pending view is read only
    if (wr_en)
    begin
      if (wr_idx == `IDX_MASK_MIRROR)
      begin
        for (int e = 0; e < 12; e++)
          d.ctl[e].source_mask = nv[e];
      end
      else if (wr_idx == `IDX_IN_SERVICE)
      begin
        for (int e = 0; e < 12; e++)
          if ((view(12'h001 << e, slave) & nv) != 16'h0000)
            d.in_service_reg[e] = 1'b0;
      end
      else if (wr_ent[4])
        d.ctl[wr_ent[3:0]] = src_ctl_t'((q.ctl[wr_ent[3:0]] & ~wmask(wr_ent[3:0]))
                                        | (nv[6:0] & wmask(wr_ent[3:0])));
    end
    // Taking an interrupt after the clear so the set wins
    if (ack_now)
      d.in_service_reg[q.sel] = 1'b1;
    // Priority resolution over eligible sources
    found = 1'b0;
    best = 4'h0;
    best_pri = 3'h7;
    for (int e = 0; e < 12; e++)
      if (elig[e] && (!found || q.ctl[e].priority_level < best_pri))
      begin
        found = 1'b1;
        best = 4'(e);
        best_pri = q.ctl[e].priority_level;
      end
    // One idle cycle after an acknowledge lets the in-service bit settle
    d.irq_req = found && !ack_now;
    d.sel = best;
    d.irq_type = type_of(best, slave, tmr_req);
    d.ack_a = ack_now && q.sel == ENT_EXT0 && q.ctl[ENT_EXT0].cascade_enable;
    d.ack_b = ack_now && q.sel == ENT_EXT1 && q.ctl[ENT_EXT1].cascade_enable;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.ctl <= {12{src_ctl_t'(`RST_CTRL)}};
      q.in_service_reg <= `RST_IN_SERVICE;
    end
    else
      q <= d;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign irq_req = q.irq_req;
  assign irq_type = q.irq_type;
  assign irq_ack_out_a = q.ack_a;
  assign irq_ack_out_b = q.ack_b;
  // Enable low while the pin is driven as an acknowledge output
  assign irq_ack_out_a_oe_n = !q.ctl[ENT_EXT0].cascade_enable;
  assign irq_ack_out_b_oe_n = !q.ctl[ENT_EXT1].cascade_enable;

endmodule
`default_nettype wire

// file: verilog/irq_ctrl_map.svh
// Register indices, field positions, reset values and vector types of the source control block
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_MASK_MIRROR 8'h28
`define IDX_IN_SERVICE 8'h2c
`define IDX_PENDING 8'h2e
`define IDX_TIMER_UNIT 8'h32
`define IDX_DMA0_EXT5 8'h34
`define IDX_DMA1_EXT6 8'h36
`define IDX_EXT0 8'h38
`define IDX_EXT1 8'h3a
`define IDX_EXT2 8'h3c
`define IDX_EXT3 8'h3e
`define IDX_EXT4 8'h40
`define IDX_SERIAL1 8'h42
`define IDX_SERIAL0 8'h44
`define IDX_TIMER0_SLAVE 8'h32
`define IDX_TIMER1_SLAVE 8'h38
`define IDX_TIMER2_SLAVE 8'h3a
// ----------------------------------------
// Field positions and writable fields
// ----------------------------------------
`define POS_SER_FIXED 4
`define WMASK_EXT01 7'h7f
`define WMASK_EXT234 7'h1f
`define WMASK_PLAIN 7'h0f
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CTRL 7'h0f
`define RST_IN_SERVICE 12'h000
// ----------------------------------------
// Vector types
// ----------------------------------------
`define TYPE_TMR0 8'h08
`define TYPE_TMR1 8'h12
`define TYPE_TMR2 8'h13
`define TYPE_DMA0 8'h0a
`define TYPE_DMA1 8'h0b
`define TYPE_EXT0 8'h0c
`define TYPE_EXT1 8'h0d
`define TYPE_EXT2 8'h0e
`define TYPE_EXT3 8'h0f
`define TYPE_EXT4 8'h10
`define TYPE_SER1 8'h16
`define TYPE_SER0 8'h17
// ----------------------------------------
// Bus responses
// ----------------------------------------
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// file: verilog/irq_ctrl_pkg.sv
// Types shared by the interrupt source control block
`default_nettype none
package irq_ctrl_pkg;
  typedef enum logic [3:0] {
    ENT_TMR = 4'b0000,
    ENT_DMA0 = 4'b0001,
    ENT_DMA1 = 4'b0010,
    ENT_EXT0 = 4'b0011,
    ENT_EXT1 = 4'b0100,
    ENT_EXT2 = 4'b0101,
    ENT_EXT3 = 4'b0110,
    ENT_EXT4 = 4'b0111,
    ENT_SER1 = 4'b1000,
    ENT_SER0 = 4'b1001,
    ENT_TMR1 = 4'b1010,
    ENT_TMR2 = 4'b1011
  } ent_t;
  typedef struct packed {
    logic special_nested_enable;
    logic cascade_enable;
    logic level_trigger_select;
    logic source_mask;
    logic [2:0] priority_level;
  } src_ctl_t;
  typedef src_ctl_t [11:0] ctl_arr_t;
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic edge_seen;
  } pin_st_t;
  typedef struct packed {
    logic aw_full;
    logic [11:0] awaddr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } axil_st_t;
  typedef struct packed {
    logic mode_s1;
    logic mode_s2;
    ctl_arr_t ctl;
    logic [11:0] in_service_reg;
    logic irq_req;
    logic [7:0] irq_type;
    logic [3:0] sel;
    logic ack_a;
    logic ack_b;
  } main_st_t;
endpackage
`default_nettype wire

// file: verilog/irq_pin_detect.sv
// Synchroniser and edge or level detector for one external request pin
`timescale 1ns/1ps
`default_nettype none
module irq_pin_detect (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Pin and control
  input wire logic pin_in,
  input wire logic level_mode,
  input wire logic clear,
  output logic req
);
  import irq_ctrl_pkg::*;
  pin_st_t q;
  pin_st_t d;
  always_comb
  begin
    d = q;
    d.sync1 = pin_in;
    d.sync2 = q.sync1;
    d.prev = q.sync2;
    // Set wins over the acknowledge clear
    d.edge_seen = (q.sync2 & ~q.prev) | (q.edge_seen & ~clear);
  end
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      q <= '0;
    else
      q <= d;
  end
  assign req = level_mode ? q.sync2 : q.edge_seen;
endmodule
`default_nettype wire
